// file: rtl/pli_phy_link.sv
// PHY side of the PHY-link parallel interface with AHB-Lite registers
// Function
// [RQ1] Link reasserts power status only after the restore interval in reset.
// [RQ2] Same initialization runs from the reset-only state as from disabled.
// [RQ3] Interface clock restarts within 60 ns, or 5.3-7.3 ms from low power.
// [RQ4] Interface clock provided; all driven lines change on its rising edge. Wake output and reset clearing of the bus change on any hclk edge.
// [RQ5] Control and data held low for the first 7 interface cycles.
// [RQ6] Link drives its lines low one of first 6 cycles, request low.
// [RQ7] Eighth cycle shows receive code with data all ones.
// [RQ8] Then idle and zeros; only afterwards are link requests accepted.
// [RQ9] Link returns a locked clock; link-to-PHY transfers follow it; the code samples only requests on it, control and data on tick.
// [RQ10] All eight data lines carry data at every beta speed.
// [RQ11] PHY owns both buses; link drives only after a grant.
// [RQ12] PHY control codes: idle, status, receive, grant.
// [RQ13] Link control codes: release, transmit, reserved, hold.
// [RQ14] Won arbitration for a bus request starts transmit by granting.
// [RQ15] Arriving packet starts a receive toward the link.
// [RQ16] Status transfer on own initiative and in answer to register reads.
// [RQ17] Link sends requests serially on request line, one bit per sample.
// [RQ18] Wake output asserted while power status inactive or link-active is 0.
// [RQ19] Serial status line shifts status information to the link.
// [RQ20] Link drops power status to reset the interface or stop its clock.
// [RQ21] Interface works only with beta select pin high.
// [RQ22] Power status low for the reset recognition time resets the interface.
// [RQ23] Restore interval the link must wait is 15 microseconds.
// [RQ24] Request stream starts with 1, ends with 0, most significant first.
// [RQ25] Link keeps request line low outside request streams.
// [RQ26] Request line activity is discarded until initialization completes.
`timescale 1ns/1ps
module pli_phy_link import pli_pkg::*; #(
  parameter int LP_CYC = PLI_LOWPWR_CYC
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Link-side pins
  input  wire logic        beta_interface_select,
  input  wire logic        link_power_status,
  input  wire logic        link_returned_clock,
  input  wire logic        link_request_line,
  input  wire logic [1:0]  control_lines_i,
  output logic [1:0]       control_lines_o,
  output logic             control_lines_oe_n,
  input  wire logic [7:0]  parallel_data_lines_i,
  output logic [7:0]       parallel_data_lines_o,
  output logic             parallel_data_lines_oe_n,
  output logic             iface_clk,
  output logic             link_wake_output,
  output logic             phy_serial_status_line
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [13:0] sync1, sync2;
  logic        rclk_d;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1  <= '0;
      sync2  <= '0;
      rclk_d <= 1'b0;
    end else begin
      sync1  <= {beta_interface_select, link_power_status, link_returned_clock,
                 link_request_line, control_lines_i, parallel_data_lines_i};
      sync2  <= sync1;
      rclk_d <= sync2[11];
    end
  end
  logic       beta_s, pwr_s, rclk_s, req_s;
  logic [1:0] ctl_s;
  logic [7:0] data_s;
  assign {beta_s, pwr_s, rclk_s, req_s, ctl_s, data_s} = sync2;
  // Requests are sampled on the returned clock, as seen through the sync
  wire rclk_edge = rclk_s & ~rclk_d; // RQ9

  // ************************************************************
  // Interface state machine
  // ************************************************************
  pli_state_t  state, next_state;
  logic [19:0] cnt, next_cnt;
  logic [11:0] pwr_cnt, next_pwr_cnt;
  pli_bus_t    bus_out, next_bus;
  logic        oe_n, next_oe_n, clk_run, next_clk_run, next_iface_clk;
  logic [7:0]  txb, next_txb;
  logic        next_wake, take_rx, take_st, take_gr;
  logic        rx_pend, st_pend, bus_pend, arb_pend;
  logic [7:0]  st_first, st_second, rxb, stb;
  logic [1:0]  ctrl;
  wire tick = clk_run & ~iface_clk;
  wire operational = (state == ST_IDLE) | (state == ST_RECV) | (state == ST_STAT) |
                     (state == ST_GRANT) | (state == ST_LINK);

  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_bus       = bus_out;
    next_oe_n      = oe_n;
    next_clk_run   = clk_run;
    next_iface_clk = clk_run & ~iface_clk; // RQ4
    next_txb       = txb;
    take_rx        = 1'b0;
    take_st        = 1'b0;
    take_gr        = 1'b0;
    next_wake      = ~pwr_s | ~ctrl[PLI_CTRL_LACT]; // RQ18
    next_pwr_cnt   = pwr_s ? 12'h000 :
                     (pwr_cnt == 12'(PLI_DIS_CYC)) ? pwr_cnt : pwr_cnt + 12'h001;
    case (state)
      ST_DISABLED: begin
        next_clk_run = 1'b0;
        next_bus     = '0;
        next_oe_n    = 1'b0;
        if (pwr_s && beta_s) begin
          next_state = ST_WAKE;
          // Low power costs a full oscillator restart
          next_cnt = ctrl[PLI_CTRL_QUIET] ? 20'(LP_CYC - 2) : 20'(PLI_CLK_ON_CYC - 2); // RQ3
        end
      end
      ST_WAKE: begin
        if (cnt == 20'h00000) begin
          next_clk_run = 1'b1; // RQ3
          next_state   = ST_INIT;
        end else begin
          next_cnt = cnt - 20'h00001;
        end
      end
      ST_RESET: begin
        if (pwr_s) begin
          next_state = ST_INIT; // RQ2
          next_cnt   = '0;
        end
      end
      ST_INIT: begin
        if (tick) begin
          next_bus  = '0; // RQ5
          next_oe_n = 1'b0;
          if (cnt == PLI_INIT_LOW) begin
            next_bus   = '{ctl: PLI_CTL_RECEIVE, data: PLI_DATA_ON}; // RQ7
            next_state = ST_RXIND;
          end else begin
            next_cnt = cnt + 20'h00001;
          end
        end
      end
      ST_RXIND: begin
        if (tick) begin
          next_bus   = '0; // RQ8
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        next_cnt = '0;
        if (tick) begin
          if (rx_pend) begin
            next_bus   = '{ctl: PLI_CTL_RECEIVE, data: PLI_DATA_ON}; // RQ15
            next_state = ST_RECV;
            take_rx    = 1'b1;
          end else if (st_pend) begin
            next_bus   = '{ctl: PLI_CTL_STATUS, data: st_first}; // RQ16
            next_state = ST_STAT;
            take_st    = 1'b1;
          end else if (bus_pend && arb_pend) begin
            next_bus   = '{ctl: PLI_CTL_GRANT, data: 8'h00}; // RQ14
            next_state = ST_GRANT;
            take_gr    = 1'b1;
          end
        end
      end
      ST_RECV: begin
        if (tick) begin
          if (cnt == 20'h00000) begin
            next_bus = '{ctl: PLI_CTL_RECEIVE, data: rxb}; // RQ10
            next_cnt = 20'h00001;
          end else begin
            next_bus   = '0;
            next_state = ST_IDLE;
          end
        end
      end
      ST_STAT: begin
        if (tick) begin
          if (cnt == 20'h00000) begin
            next_bus = '{ctl: PLI_CTL_STATUS, data: st_second}; // RQ12
            next_cnt = 20'h00001;
          end else begin
            next_bus   = '0;
            next_state = ST_IDLE;
          end
        end
      end
      ST_GRANT: begin
        if (tick) begin
          next_oe_n  = 1'b1; // RQ11
          next_state = ST_LINK;
        end
      end
      ST_LINK: begin
        // Release counts only after the link has driven something else
        if (tick) begin
          if (ctl_s != PLI_LCTL_RELEASE) begin
            next_cnt = 20'h00001;
            if (ctl_s == PLI_LCTL_TX) next_txb = data_s; // RQ10
          end else if (cnt[0]) begin
            next_oe_n  = 1'b0;
            next_bus   = '0;
            next_state = ST_IDLE;
          end
        end
      end
      default: next_state = ST_DISABLED;
    endcase
    if (!beta_s) begin
      next_state   = ST_DISABLED; // RQ21
      next_clk_run = 1'b0;
      next_bus     = '0;
      next_oe_n    = 1'b0;
    end else if (!pwr_s && state != ST_DISABLED && state != ST_WAKE) begin
      if (pwr_cnt >= 12'(PLI_DIS_CYC - 1)) begin
        next_state   = ST_DISABLED;
        next_clk_run = 1'b0;
        next_bus     = '0;
        next_oe_n    = 1'b0;
      end else if (pwr_cnt >= 12'(PLI_RESET_CYC - 1) && state != ST_RESET) begin
        next_state = ST_RESET; // RQ22
        next_bus   = '0;
        next_oe_n  = 1'b0;
      end
    end
    if (!next_clk_run) next_iface_clk = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state            <= ST_DISABLED;
      cnt              <= '0;
      pwr_cnt          <= '0;
      bus_out          <= '0;
      oe_n             <= 1'b0;
      clk_run          <= 1'b0;
      iface_clk        <= 1'b0;
      txb              <= '0;
      link_wake_output <= 1'b1;
    end else begin
      state            <= next_state;
      cnt              <= next_cnt;
      pwr_cnt          <= next_pwr_cnt;
      bus_out          <= next_bus;
      oe_n             <= next_oe_n;
      clk_run          <= next_clk_run;
      iface_clk        <= next_iface_clk;
      txb              <= next_txb;
      link_wake_output <= next_wake;
    end
  end

  // ************************************************************
  // Request decoder, pending work and serial status
  // ************************************************************
  function automatic logic [4:0] req_len(input logic [3:0] t);
    case (t)
      PLI_RT_READ:  req_len = PLI_LEN_READ;
      PLI_RT_WRITE: req_len = PLI_LEN_WRITE;
      4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8: req_len = PLI_LEN_BUS;
      default: req_len = PLI_LEN_SHORT;
    endcase
  endfunction

  logic        rq_busy, next_rq_busy, st_read, next_st_read, ser_pend, next_ser_pend;
  logic [4:0]  rq_cnt, next_rq_cnt;
  logic [17:0] rq_sh, next_rq_sh, w;
  logic [3:0]  rq_type, next_rq_type, st_addr, next_st_addr, wr_addr;
  logic [21:0] last_req, next_last_req;
  logic        next_rx_pend, next_st_pend, next_bus_pend, next_arb_pend;
  logic        req_done, wr_en, cmd_arb, cmd_rx, cmd_st, cmd_ser;
  logic [7:0]  wr_data;
  logic [9:0]  ser_sh, next_ser_sh;
  logic [7:0]  phy_regs [16];
  assign st_first  = {st_addr, 4'h0};
  assign st_second = st_read ? phy_regs[st_addr] : stb;
  assign phy_serial_status_line = ser_sh[9]; // RQ19

  always_comb begin
    w             = {rq_sh[16:0], req_s};
    next_rq_busy  = rq_busy;
    next_rq_cnt   = rq_cnt;
    next_rq_sh    = rq_sh;
    next_rq_type  = rq_type;
    next_last_req = last_req;
    next_st_read  = st_read;
    next_st_addr  = st_addr;
    next_ser_sh   = ser_sh;
    next_ser_pend = ser_pend | cmd_ser;
    req_done      = 1'b0;
    wr_en         = 1'b0;
    wr_addr       = w[12:9];
    wr_data       = w[8:1];
    if (!operational) begin
      next_rq_busy = 1'b0; // RQ26
      next_rq_cnt  = '0;
    end else if (rclk_edge) begin
      if (!rq_busy) begin
        if (req_s) begin
          next_rq_busy = 1'b1; // RQ17
          next_rq_cnt  = 5'h01;
          next_rq_sh   = 18'h00001;
        end
      end else begin
        next_rq_sh  = w;
        next_rq_cnt = rq_cnt + 5'h01;
        if (next_rq_cnt == 5'h05) next_rq_type = w[3:0];
        if (next_rq_cnt == req_len(rq_type)) begin
          req_done      = 1'b1;
          next_rq_busy  = 1'b0;
          next_last_req = {rq_type, w};
        end
      end
    end
    wr_en = req_done & (rq_type == PLI_RT_WRITE);
    if (cmd_st) begin
      next_st_read = 1'b0;
      next_st_addr = 4'h0;
    end
    if (req_done && rq_type == PLI_RT_READ) begin
      next_st_read = 1'b1; // RQ16
      next_st_addr = w[4:1];
    end
    // Hardware sets win over the clears from the state machine
    next_rx_pend  = operational & (cmd_rx | (rx_pend & ~take_rx));
    next_st_pend  = operational & (cmd_st | (req_done & rq_type == PLI_RT_READ) |
                                   (st_pend & ~take_st));
    next_bus_pend = operational & ((req_done & req_len(rq_type) == PLI_LEN_BUS) |
                                   (bus_pend & ~take_gr));
    next_arb_pend = operational & (cmd_arb | (arb_pend & ~take_gr));
    if (tick) begin
      if (|ser_sh) begin
        next_ser_sh = {ser_sh[8:0], 1'b0};
      end else if (ser_pend) begin
        next_ser_sh   = {1'b1, stb, 1'b0};
        next_ser_pend = cmd_ser;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rq_busy  <= 1'b0;
      rq_cnt   <= '0;
      rq_sh    <= '0;
      rq_type  <= '0;
      last_req <= '0;
      st_read  <= 1'b0;
      st_addr  <= '0;
      rx_pend  <= 1'b0;
      st_pend  <= 1'b0;
      bus_pend <= 1'b0;
      arb_pend <= 1'b0;
      ser_pend <= 1'b0;
      ser_sh   <= '0;
      for (int i = 0; i < 16; i++) phy_regs[i] <= 8'h00;
    end else begin
      rq_busy  <= next_rq_busy;
      rq_cnt   <= next_rq_cnt;
      rq_sh    <= next_rq_sh;
      rq_type  <= next_rq_type;
      last_req <= next_last_req;
      st_read  <= next_st_read;
      st_addr  <= next_st_addr;
      rx_pend  <= next_rx_pend;
      st_pend  <= next_st_pend;
      bus_pend <= next_bus_pend;
      arb_pend <= next_arb_pend;
      ser_pend <= next_ser_pend;
      ser_sh   <= next_ser_sh;
      if (wr_en) phy_regs[wr_addr] <= wr_data;
    end
  end

  // ************************************************************
  // AHB-Lite register slave
  // ************************************************************
  logic        dp_wr, next_dp_wr;
  logic [7:0]  dp_addr, next_dp_addr, next_rxb, next_stb;
  logic [1:0]  next_ctrl;
  logic [31:0] next_hrdata;
  wire         aphase = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    next_dp_wr   = aphase & hwrite;
    next_dp_addr = aphase ? haddr[7:0] : dp_addr;
    next_ctrl    = ctrl;
    next_rxb     = rxb;
    next_stb     = stb;
    next_hrdata  = hrdata;
    cmd_arb      = 1'b0;
    cmd_rx       = 1'b0;
    cmd_st       = 1'b0;
    cmd_ser      = 1'b0;
    if (dp_wr) begin
      case (dp_addr)
        PLI_CTRL_OFS: next_ctrl = hwdata[1:0];
        PLI_CMD_OFS: begin
          cmd_arb = hwdata[PLI_CMD_ARB];
          cmd_rx  = hwdata[PLI_CMD_RX];
          cmd_st  = hwdata[PLI_CMD_ST];
          cmd_ser = hwdata[PLI_CMD_SER];
        end
        PLI_RXB_OFS: next_rxb = hwdata[7:0];
        PLI_STB_OFS: next_stb = hwdata[7:0];
        default: ;
      endcase
    end
    if (aphase && !hwrite) begin
      next_hrdata = '0;
      case (haddr[7:0])
        PLI_CTRL_OFS: next_hrdata[1:0] = ctrl;
        PLI_RXB_OFS:  next_hrdata[7:0] = rxb;
        PLI_STB_OFS:  next_hrdata[7:0] = stb;
        PLI_STATE_OFS: begin
          next_hrdata[9:0]           = state;
          next_hrdata[PLI_ST_OPER]   = operational;
          next_hrdata[PLI_ST_PEND]   = bus_pend;
          next_hrdata[PLI_ST_PWR]    = pwr_s;
          next_hrdata[PLI_ST_TXB+:8] = txb;
        end
        PLI_LAST_OFS: next_hrdata[21:0] = last_req;
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= '0;
      ctrl    <= PLI_CTRL_RST;
      rxb     <= '0;
      stb     <= '0;
      hrdata  <= '0;
    end else begin
      dp_wr   <= next_dp_wr;
      dp_addr <= next_dp_addr;
      ctrl    <= next_ctrl;
      rxb     <= next_rxb;
      stb     <= next_stb;
      hrdata  <= next_hrdata;
    end
  end

  assign control_lines_o          = bus_out.ctl;
  assign parallel_data_lines_o    = bus_out.data;
  assign control_lines_oe_n       = oe_n;
  assign parallel_data_lines_oe_n = oe_n;

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_rx_ind;
    state == ST_RXIND && bus_out == {PLI_CTL_RECEIVE, PLI_DATA_ON};
  endsequence
  sequence s_idle_zero;
    state == ST_IDLE && bus_out == '0 && !oe_n;
  endsequence
  a_init_low: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
    state == ST_INIT |-> bus_out == '0 && !oe_n) else $error("init not low");
  a_rx_indicate: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
    $rose(state == ST_RXIND) |-> s_rx_ind) else $error("bad receive indication");
  a_init_done: assert property (@(posedge hclk) disable iff (!hresetn) // RQ8
    s_rx_ind ##0 tick ##1 pwr_s && beta_s |-> s_idle_zero) else $error("init end wrong");
  a_clk_restart: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
    $rose(state == ST_WAKE) && !ctrl[PLI_CTRL_QUIET] |-> ##[1:6] clk_run)
    else $error("clock restart late");
  a_edge_only: assert property (@(posedge hclk) disable iff (!hresetn) // RQ4
    $changed(bus_out) && $past(pwr_s) && $past(beta_s) && $past(operational)
    |-> $past(tick)) else $error("bus moved off clock edge");
  a_grant_own: assert property (@(posedge hclk) disable iff (!hresetn) // RQ14
    $rose(state == ST_LINK) |-> oe_n && $past(bus_out.ctl) == PLI_CTL_GRANT)
    else $error("link owns bus without grant");
  a_link_owned: assert property (@(posedge hclk) disable iff (!hresetn) // RQ11
    oe_n |-> state == ST_LINK) else $error("released bus outside grant");
  a_wake_out: assert property (@(posedge hclk) disable iff (!hresetn) // RQ18
    !pwr_s || !ctrl[PLI_CTRL_LACT] |=> link_wake_output) else $error("no wake");
  a_req_ignore: assert property (@(posedge hclk) disable iff (!hresetn) // RQ26
    !operational |=> !rq_busy && !bus_pend) else $error("request kept in reset");
  a_pwr_reset: assert property (@(posedge hclk) disable iff (!hresetn) // RQ22
    beta_s && !pwr_s && operational && pwr_cnt == 12'(PLI_RESET_CYC - 1)
    |=> state == ST_RESET && bus_out == '0) else $error("reset not recognised");
  a_beta_off: assert property (@(posedge hclk) disable iff (!hresetn) // RQ21
    !beta_s |=> state == ST_DISABLED && !clk_run) else $error("active without beta");
endmodule // pli_phy_link

// file: rtl/pli_pkg.sv
// Constants and types of the PHY-link parallel interface block
package pli_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] PLI_CTRL_OFS   = 8'h00;
  localparam logic [7:0] PLI_CMD_OFS    = 8'h04;
  localparam logic [7:0] PLI_RXB_OFS    = 8'h08;
  localparam logic [7:0] PLI_STB_OFS    = 8'h0c;
  localparam logic [7:0] PLI_STATE_OFS  = 8'h10;
  localparam logic [7:0] PLI_LAST_OFS   = 8'h14;
  localparam int         PLI_CTRL_LACT  = 0;
  localparam int         PLI_CTRL_QUIET = 1;
  localparam logic [1:0] PLI_CTRL_RST   = 2'h2;
  localparam int         PLI_CMD_ARB    = 0;
  localparam int         PLI_CMD_RX     = 1;
  localparam int         PLI_CMD_ST     = 2;
  localparam int         PLI_CMD_SER    = 3;
  localparam int         PLI_ST_OPER    = 16;
  localparam int         PLI_ST_PEND    = 17;
  localparam int         PLI_ST_PWR     = 18;
  localparam int         PLI_ST_TXB     = 24;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int PLI_CLK_NS     = 10;
  localparam int PLI_RESET_NS   = 2600;
  localparam int PLI_DISABLE_NS = 26030;
  localparam int PLI_CLK_ON_NS  = 60;
  localparam int PLI_LOWPWR_NS  = 5300000;
  localparam int PLI_RESET_CYC  = (PLI_RESET_NS + PLI_CLK_NS - 1) / PLI_CLK_NS;
  localparam int PLI_DIS_CYC    = (PLI_DISABLE_NS + PLI_CLK_NS - 1) / PLI_CLK_NS;
  localparam int PLI_CLK_ON_CYC = PLI_CLK_ON_NS / PLI_CLK_NS;
  localparam int PLI_LOWPWR_CYC = (PLI_LOWPWR_NS + PLI_CLK_NS - 1) / PLI_CLK_NS;
  localparam logic [19:0] PLI_INIT_LOW = 20'h00007;
  // ************************************************************
  // Codes
  // ************************************************************
  localparam logic [1:0] PLI_CTL_IDLE     = 2'h0;
  localparam logic [1:0] PLI_CTL_STATUS   = 2'h1;
  localparam logic [1:0] PLI_CTL_RECEIVE  = 2'h2;
  localparam logic [1:0] PLI_CTL_GRANT    = 2'h3;
  localparam logic [1:0] PLI_LCTL_RELEASE = 2'h0;
  localparam logic [1:0] PLI_LCTL_TX      = 2'h1;
  localparam logic [7:0] PLI_DATA_ON      = 8'hff;
  localparam logic [3:0] PLI_RT_READ      = 4'ha;
  localparam logic [3:0] PLI_RT_WRITE     = 4'hb;
  localparam logic [4:0] PLI_LEN_BUS      = 5'h0b;
  localparam logic [4:0] PLI_LEN_READ     = 5'h0a;
  localparam logic [4:0] PLI_LEN_WRITE    = 5'h12;
  localparam logic [4:0] PLI_LEN_SHORT    = 5'h06;
  typedef enum logic [9:0] {
    ST_DISABLED = 10'h001, ST_WAKE = 10'h002, ST_RESET = 10'h004,
    ST_INIT     = 10'h008, ST_RXIND = 10'h010, ST_IDLE = 10'h020,
    ST_RECV     = 10'h040, ST_STAT = 10'h080, ST_GRANT = 10'h100,
    ST_LINK     = 10'h200
  } pli_state_t;
  typedef struct packed {
    logic [1:0] ctl;
    logic [7:0] data;
  } pli_bus_t;
endpackage

// file: sim/pli_link_model.sv
// Link-layer partner model on the far side of the parallel interface
`timescale 1ns/1ps
module pli_link_model import pli_pkg::*; (
  // PHY side
  input  wire logic     iface_clk,
  input  wire pli_bus_t phy_bus,
  input  wire logic     phy_oe_n,
  // Link side
  output logic          link_returned_clock,
  output logic          link_request_line,
  output pli_bus_t      wire_bus
);
  pli_bus_t   own;
  logic [1:0] tx;
  assign link_returned_clock = iface_clk;
  assign wire_bus = phy_oe_n ? own : phy_bus;
  initial begin
    link_request_line = 1'b0;
    own = '0;
    tx = 2'h0;
  end
  // Transmit held two ticks so the PHY sync stage cannot miss it
  // Sampled mid-period, where PHY outputs have settled
  always @(negedge iface_clk) begin
    if (!phy_oe_n && phy_bus.ctl === PLI_CTL_GRANT)
      tx <= 2'h1;
    else if (tx != 2'h0)
      tx <= tx + 2'h1;
    own <= (tx == 2'h1 || tx == 2'h2) ? pli_bus_t'({PLI_LCTL_TX, 8'h5a}) : '0;
  end
  task send(input logic [17:0] b, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge iface_clk);
      link_request_line <= b[i];
    end
    @(posedge iface_clk);
    link_request_line <= 1'b0;
  endtask
endmodule // pli_link_model

// file: sim/pli_phy_link_tb_top.sv
// Testbench of the PHY-link parallel interface block
`timescale 1ns/1ps
module pli_phy_link_tb_top import pli_pkg::*;;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, link_power_status = 0;
  logic [1:0] htrans = 0, control_lines_i, control_lines_o;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [7:0] parallel_data_lines_i, parallel_data_lines_o;
  logic hready, hreadyout, hresp, beta_interface_select = 1, link_returned_clock;
  logic link_request_line, control_lines_oe_n, parallel_data_lines_oe_n;
  logic iface_clk, link_wake_output, phy_serial_status_line;
  pli_bus_t wb;
  int fail_count = 0, checked = 0, cyc = 0;
  assign hready = hreadyout;
  assign {control_lines_i, parallel_data_lines_i} = wb;
  always #5 hclk = ~hclk;
  pli_phy_link #(.LP_CYC(20)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .beta_interface_select, .link_power_status,
    .link_returned_clock, .link_request_line, .control_lines_i, .control_lines_o,
    .control_lines_oe_n, .parallel_data_lines_i, .parallel_data_lines_o,
    .parallel_data_lines_oe_n, .iface_clk, .link_wake_output, .phy_serial_status_line);
  pli_link_model lnk (.iface_clk, .phy_bus({control_lines_o, parallel_data_lines_o}),
    .phy_oe_n(control_lines_oe_n), .link_returned_clock, .link_request_line, .wire_bus(wb));
  task final_report;
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task ck(input bit ok, input string m);
    checked++;
    if (!ok) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  function logic [9:0] bus();
    return {control_lines_o, parallel_data_lines_o};
  endfunction
  task nx;
    @(negedge iface_clk);
  endtask
  task wfor(input logic [1:0] c);
    int n;
    for (n = 0; n < 200 && control_lines_o !== c; n++) nx;
    ck(n < 200, "code missing");
  endtask
  task t_init(input bit ex);
    int n;
    n = 0;
    link_power_status <= 1'b1;
    @(posedge iface_clk);
    nx;
    while (n < 300 && bus() === 10'h0) begin
      n++;
      nx;
    end
    ck(ex ? n == 7 : n >= 7, "init low count");
    ck(bus() === {PLI_CTL_RECEIVE, PLI_DATA_ON}, "init receive");
    while (n < 400 && bus() === {PLI_CTL_RECEIVE, PLI_DATA_ON}) begin
      n++;
      nx;
    end
    ck(bus() === 10'h0, "init idle");
  endtask
  task t_reg;
    lnk.send({1'b1, PLI_RT_WRITE, 4'h3, 8'h96, 1'b0}, 18);
    lnk.send({8'h0, 1'b1, PLI_RT_READ, 4'h3, 1'b0}, 10);
    wfor(PLI_CTL_STATUS);
    ck(bus() === {PLI_CTL_STATUS, 8'h30}, "status addr");
    nx;
    ck(bus() === {PLI_CTL_STATUS, 8'h96}, "status value");
    nx;
    ck(bus() === 10'h0, "status end");
    ahb(0, PLI_LAST_OFS, 32'h0);
    ck(rd[21:0] === {PLI_RT_READ, 9'h1, PLI_RT_READ, 4'h3, 1'b0}, "last request");
  endtask
  task t_recv;
    ahb(1, PLI_RXB_OFS, 32'ha5);
    ahb(1, PLI_CMD_OFS, 32'h2);
    wfor(PLI_CTL_RECEIVE);
    ck(bus() === {PLI_CTL_RECEIVE, PLI_DATA_ON}, "rx on");
    nx;
    ck(bus() === {PLI_CTL_RECEIVE, 8'ha5}, "rx byte");
    nx;
    ck(bus() === 10'h0, "rx end");
  endtask
  task t_ser;
    logic [9:0] v;
    ahb(1, PLI_STB_OFS, 32'hc3);
    ahb(1, PLI_CMD_OFS, 32'hc);
    wfor(PLI_CTL_STATUS);
    ck(bus() === {PLI_CTL_STATUS, 8'h00}, "auto status addr");
    for (int i = 0; i < 10; i++) begin
      v = {v[8:0], phy_serial_status_line};
      if (i == 1) ck(bus() === {PLI_CTL_STATUS, 8'hc3}, "auto status value");
      nx;
    end
    ck(v === {1'b1, 8'hc3, 1'b0}, "serial status");
  endtask
  task t_grant;
    int n;
    lnk.send({7'h0, 1'b1, 4'h1, 1'b0, 4'h0, 1'b0}, 11);
    ahb(1, PLI_CMD_OFS, 32'h1);
    wfor(PLI_CTL_GRANT);
    nx;
    ck(control_lines_oe_n === 1'b1 && parallel_data_lines_oe_n === 1'b1, "no handover");
    for (n = 0; n < 50 && control_lines_oe_n !== 1'b0; n++) nx;
    ck(n < 50 && bus() === 10'h0, "no resume");
    ahb(0, PLI_STATE_OFS, 32'h0);
    ck(rd[31:24] === 8'h5a, "tx byte");
  endtask
  task t_wake;
    ahb(1, PLI_CTRL_OFS, 32'h1);
    ahb(0, 8'h40, 32'h0);
    ck(rd === 32'h0, "unmapped read");
    ck(link_wake_output === 1'b0, "wake stuck");
  endtask
  task t_lreset(input int hold);
    link_power_status <= 1'b0;
    repeat (272) @(posedge hclk);
    ahb(0, PLI_STATE_OFS, 32'h0);
    ck(rd[9:0] === 10'h004 && bus() === 10'h0, "no reset");
    ck(link_wake_output === 1'b1, "wake off");
    repeat (hold) @(posedge hclk);
    ahb(0, PLI_STATE_OFS, 32'h0);
    ck(rd[9:0] === (hold > 2000 ? 10'h001 : 10'h004), "no disable");
    t_init(hold > 2000);
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      final_report;
    end
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ck(link_wake_output === 1'b1, "wake reset");
    t_init(1);
    t_reg;
    t_recv;
    t_ser;
    t_grant;
    t_wake;
    t_lreset(1500);
    t_lreset(2400);
    beta_interface_select <= 1'b0;
    repeat (4) @(posedge hclk);
    ahb(0, PLI_STATE_OFS, 32'h0);
    ck(rd[9:0] === 10'h001 && iface_clk === 1'b0, "beta off");
    final_report;
  end
endmodule // pli_phy_link_tb_top
